//--- csgoc_ctrl.v
// shutdown/gating, output steering and capture gate control words
// assumes time base, capture and compare logic outside give
// rollover and event pulses; apb master per amba apb3
// inputs are taken as synchronous to ref_clk
// a single-output build keeps only pin a; others read zero
// status flag bits: write 0 clears, write 1 leaves as is; arm bit 10 arms on write 1
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "csgoc_regs.vh"
module csgoc_ctrl #(
  parameter MULTI_OUT = 1
) (
  ref_clk,
  reset,
  // apb slave side
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  // shutdown and gating source levels
  comparator_1,
  comparator_2,
  comparator_3,
  fault_input_a,
  fault_input_b,
  fault_input_c,
  fault_input_d,
  logic_cell_1,
  logic_cell_2,
  logic_cell_3,
  logic_cell_4,
  // capture pin and own capture input
  capture_pin,
  own_capture,
  // time base and event pulses
  timebase_roll,
  capture_event,
  compare_event,
  // operating mode levels
  mode_signal,
  timer_mode,
  // status flags and steering outputs
  shutdown_active_flag,
  capture_disable_flag,
  pin_drive_enables,
  capture_source,
  capture_gated,
  aux_out
);
  input wire ref_clk;
  input wire reset;
  // apb slave side
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [11:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output reg pready;
  output reg pslverr;
  // shutdown and gating source levels
  input wire comparator_1;
  input wire comparator_2;
  input wire comparator_3;
  input wire fault_input_a;
  input wire fault_input_b;
  input wire fault_input_c;
  input wire fault_input_d;
  input wire logic_cell_1;
  input wire logic_cell_2;
  input wire logic_cell_3;
  input wire logic_cell_4;
  // capture pin and own capture input
  input wire capture_pin;
  input wire own_capture;
  // time base and event pulses
  input wire timebase_roll;
  input wire capture_event;
  input wire compare_event;
  // operating mode levels
  input wire mode_signal;
  input wire timer_mode;
  // status flags and steering outputs
  output wire shutdown_active_flag;
  output wire capture_disable_flag;
  output reg [5:0] pin_drive_enables;
  output reg capture_source;
  output reg capture_gated;
  output reg aux_out;

  // implemented bits depend on instance kind
  localparam [15:0] OSCC_MASK = MULTI_OUT ? `CSGOC_OSCC_MASK_MULTI :
                                            `CSGOC_OSCC_MASK_SINGLE;
  // shutdown/gating control word
  reg [15:0] sdgc_r;
  // output steering/capture control word
  reg [15:0] oscc_r;
  // one-shot gate armed
  reg armed_r;
  // shutdown request seen waiting for boundary
  reg pend_r;
  // access phase decode
  // pready is folded in, though it only drops in reset
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire wr_sdgc = wr & (paddr == `CSGOC_OFF_SDGC);
  wire wr_oscc = wr & (paddr == `CSGOC_OFF_OSCC);
  wire wr_stat = wr & (paddr == `CSGOC_OFF_STAT);
  // status word holds the two flags and the arm bit
  wire mapped = (paddr == `CSGOC_OFF_SDGC) | (paddr == `CSGOC_OFF_OSCC) |
                (paddr == `CSGOC_OFF_STAT);

  // source mapping
  // bit order follows the source enable field
  wire [7:0] sources = {fault_input_b, fault_input_a, logic_cell_1, own_capture,
                        fault_input_d, fault_input_c, comparator_2, comparator_1};
  // enabled sources ORed with software bit
  wire sd_req = (|(sources & sdgc_r[7:0])) | sdgc_r[`CSGOC_BIT_SWSD];
  // gate mode waits for rollover
  // in gate mode the flag sets only on a rollover pulse
  wire sd_now = sdgc_r[`CSGOC_BIT_GATEMODE] ? ((sd_req | pend_r) & timebase_roll) :
                sd_req;
  // auto clear at period start once request gone
  // a request still present at the boundary keeps the flag set
  wire sd_autoclr = sdgc_r[`CSGOC_BIT_RESTART] & timebase_roll & ~sd_req;
  // software clears whether restart is on or off (write 0 to flag)
  // writing 1 to the status bit leaves it alone
  wire sd_swclr = wr_stat & ~pwdata[`CSGOC_BIT_SDFLAG];

  // apb slave, one wait-free cycle, pready always high after reset
  // no wait states: the slave never stalls the bus
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
    end
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sdgc_r <= 16'h0000;
      oscc_r <= 16'h0000;
    end else begin
      // mask unimplemented bits
      // reserved bits never store, so they read back zero
      if (wr_sdgc) begin
        sdgc_r <= pwdata[15:0] & `CSGOC_SDGC_MASK;
      end
      if (wr_oscc) begin
        oscc_r <= pwdata[15:0] & OSCC_MASK;
      end
    end
  end

  // read mux and error answer
  // prdata loads in setup so it stands for the whole access
  // an unmapped address answers with an error and zero data
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable) begin
        case (paddr)
          `CSGOC_OFF_SDGC: prdata <= {16'h0000, sdgc_r};
          `CSGOC_OFF_OSCC: prdata <= {16'h0000, oscc_r};
          // arm bit reads zero
          `CSGOC_OFF_STAT: prdata <= {27'h0000000, shutdown_active_flag, 1'b0,
                                      capture_disable_flag, 2'h0};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // pending shutdown awaiting boundary
  // a request that comes and goes before the boundary still counts
  // leaving gate mode drops any pending request
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pend_r <= 1'b0;
    end else if (sd_now | ~sdgc_r[`CSGOC_BIT_GATEMODE]) begin
      pend_r <= 1'b0;
    end else if (sd_req) begin
      pend_r <= 1'b1;
    end
  end

  // shutdown flag, set beats clear
  // software clear and auto clear both lose to a new event
  csgoc_flag u_sdflag (
    .ref_clk(ref_clk),
    .reset(reset),
    .set_in(sd_now),
    .hw_clr(sd_autoclr),
    .sw_clr(sd_swclr),
    .flag(shutdown_active_flag)
  );

  // capture source select
  // plain mux; capture_source adds the one flop
  reg src_sel;
  always @* begin
    case (oscc_r[2:0])
      3'h0: src_sel = capture_pin;
      3'h1: src_sel = comparator_1;
      3'h2: src_sel = comparator_2;
      3'h3: src_sel = comparator_3;
      3'h4: src_sel = logic_cell_1;
      3'h5: src_sel = logic_cell_2;
      3'h6: src_sel = logic_cell_3;
      default: src_sel = logic_cell_4;
    endcase
  end

  // gating source is the combined shutdown/gate request
  // the detector starts low, like the idle request after reset
  wire g_rise;
  wire g_fall;
  csgoc_edge u_gedge (
    .ref_clk(ref_clk),
    .reset(reset),
    .level_in(sd_req),
    .rise(g_rise),
    .fall(g_fall)
  );

  // capture gating one-shot events
  wire [1:0] gmode = oscc_r[7:6];
  // arm write from software
  // arm is write-only; the read mux returns zero for it
  wire arm_wr = wr_stat & pwdata[`CSGOC_BIT_ARM];
  wire cap_off = armed_r & (gmode == `CSGOC_GATE_FALL) & g_fall;
  wire cap_on = armed_r & (gmode == `CSGOC_GATE_RISE) & g_rise;

  // arm latch, consumed by one gate event
  // a fresh arm in the event cycle wins, so no arm is lost
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      armed_r <= 1'b0;
    end else if (arm_wr) begin
      armed_r <= 1'b1;
    end else if (cap_on | cap_off) begin
      armed_r <= 1'b0;
    end
  end

  // level mode follows source, 11 holds flag
  // mode 11 drives neither input, so the flag keeps its value
  // in level mode the source level outruns a software clear
  wire lvl = (gmode == `CSGOC_GATE_LEVEL);
  csgoc_flag u_capdis (
    .ref_clk(ref_clk),
    .reset(reset),
    .set_in(cap_off | (lvl & ~sd_req)),
    .hw_clr(cap_on | (lvl & sd_req)),
    .sw_clr(wr_stat & ~pwdata[`CSGOC_BIT_CAPDIS]),
    .flag(capture_disable_flag)
  );

  // pin enables, optionally deferred to rollover
  // without sync the pins follow one cycle after the write
  // a single-output build has bits 13:9 masked, so pins b to f stay 0
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pin_drive_enables <= 6'h00;
    end else if (~oscc_r[`CSGOC_BIT_PINSYNC] | timebase_roll) begin
      // enable bits gated by instance mask
      pin_drive_enables <= oscc_r[13:8];
    end
  end

  // capture path and aux output
  // aux pulses come one cycle after the events themselves
  // timer mode blocks only the event select
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      capture_source <= 1'b0;
      capture_gated <= 1'b0;
      aux_out <= 1'b0;
    end else begin
      capture_source <= src_sel;
      capture_gated <= capture_event & ~capture_disable_flag;
      case (oscc_r[4:3])
        // event pulses, none in timer mode
        `CSGOC_AUX_EVT: aux_out <= (capture_event | compare_event) & ~timer_mode;
        `CSGOC_AUX_MODE: aux_out <= mode_signal;
        `CSGOC_AUX_ROLL: aux_out <= timebase_roll;
        default: aux_out <= 1'b0;
      endcase
    end
  end
endmodule

//--- csgoc_regs.vh
// constants for the shutdown/gating and output steering control block
// assumes a 32-bit apb slave with byte addresses, registers one word each
//
// What this block does
// - auto restart clears shutdown flag next period
// - gate mode delays shutdown to period boundary
// - software shutdown bit forces gate event
// - eight per-source shutdown enables
// - fixed mapping of eight shutdown sources
// - pin enable sync defers enable changes
// - pin enables hand pins to module
// - pins b to f only multi-output
// - mode 10 falling edge disables capture
// - mode 01 rising edge enables capture
// - mode 00 level gating, 11 reserved
// - aux select 11 capture/compare events
// - aux 10 mode signal, 01 rollover, 00 off
// - capture source select pin/comparators/logic cells
// - unimplemented bits ignore writes, read zero
// - shutdown flag is only reported; pin enables are not forced
// - capture disable flag blocks capture events at capture_gated; aux select 11 still passes them
`ifndef CSGOC_REGS_VH
`define CSGOC_REGS_VH
`define CSGOC_OFF_SDGC 12'h000
`define CSGOC_OFF_OSCC 12'h004
`define CSGOC_OFF_STAT 12'h008
`define CSGOC_SDGC_MASK 16'hD0FF
`define CSGOC_OSCC_MASK_MULTI 16'hBFDF
`define CSGOC_OSCC_MASK_SINGLE 16'h81DF
`define CSGOC_BIT_RESTART 15
`define CSGOC_BIT_GATEMODE 14
`define CSGOC_BIT_SWSD 12
`define CSGOC_BIT_PINSYNC 15
`define CSGOC_BIT_SDFLAG 4
`define CSGOC_BIT_CAPDIS 2
`define CSGOC_BIT_ARM 10
`define CSGOC_GATE_LEVEL 2'h0
`define CSGOC_GATE_RISE 2'h1
`define CSGOC_GATE_FALL 2'h2
`define CSGOC_AUX_OFF 2'h0
`define CSGOC_AUX_ROLL 2'h1
`define CSGOC_AUX_MODE 2'h2
`define CSGOC_AUX_EVT 2'h3
`endif

//--- csgoc_edge.v
// rising/falling edge detector on one synchronous level
// assumes the input is already in the ref_clk domain
`timescale 1ns/1ps
module csgoc_edge (
  ref_clk,
  reset,
  level_in,
  rise,
  fall
);
  input wire ref_clk;
  input wire reset;
  input wire level_in;
  output wire rise;
  output wire fall;
  // previous sample
  reg last_r;
  // remember last level
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      last_r <= 1'b0;
    end else begin
      last_r <= level_in;
    end
  end
  assign rise = level_in & ~last_r;
  assign fall = ~level_in & last_r;
endmodule

//--- csgoc_flag.v
// one sticky flag with hardware set, hardware clear and software clear
// assumes set and clear pulses are in the ref_clk domain
`timescale 1ns/1ps
module csgoc_flag (
  ref_clk,
  reset,
  set_in,
  hw_clr,
  sw_clr,
  flag
);
  input wire ref_clk;
  input wire reset;
  input wire set_in;
  input wire hw_clr;
  input wire sw_clr;
  output reg flag;
  // set always wins so no event is lost
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      flag <= 1'b0;
    end else if (set_in) begin
      flag <= 1'b1;
    end else if (hw_clr | sw_clr) begin
      flag <= 1'b0;
    end
  end
endmodule

//--- csgoc_ctrl_monitor.sv
// checker for the shutdown/gating control block
// assumes it is bound onto csgoc_ctrl, one clock domain
`timescale 1ns/1ps
module csgoc_monitor #(
  parameter MULTI_OUT = 1
) (
  input wire ref_clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire timebase_roll,
  input wire capture_event,
  input wire shutdown_active_flag,
  input wire capture_disable_flag,
  input wire [5:0] pin_drive_enables,
  input wire capture_gated
);
  // access phase, and a status write that clears the flag
  wire acc = psel && penable;
  wire swclr = acc && pwrite && paddr == 12'h008 && !pwdata[4];
  // single-output build hides pins b to f
  wire [15:0] mask4 = MULTI_OUT ? 16'hBFDF : 16'h81DF;
  // pin enables as the build can store them
  wire [5:0] pin_wr = pwdata[13:8] & mask4[13:8];
  // restart bit as last written, for the auto clear case
  reg rst_en_r;
  wire autoclr = timebase_roll && rst_en_r;
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rst_en_r <= 1'b0;
    end else if (acc && pwrite && paddr == 12'h000) begin
      rst_en_r <= pwdata[15];
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  property p_unmap; acc && paddr > 12'h008 |-> pslverr && prdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
  property p_upper; acc && !pwrite |-> prdata[31:16] == 16'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read half not zero");
  property p_mask0; acc && !pwrite && paddr == 12'h000 |-> (prdata[15:0] & ~16'hD0FF) == 16'h0;
  endproperty
  a_mask0: assert property (p_mask0) else $error("gating word spare bit set");
  property p_mask4; acc && !pwrite && paddr == 12'h004 |-> (prdata[15:0] & ~mask4) == 16'h0;
  endproperty
  a_mask4: assert property (p_mask4) else $error("steering word spare bit set");
  property p_gated; capture_gated |-> $past(capture_event) && !$past(capture_disable_flag);
  endproperty
  a_gated: assert property (p_gated) else $error("capture passed while disabled");
  property p_swsd; acc && pwrite && paddr == 12'h000 && pwdata[12] && !pwdata[14]
    |-> ##[1:3] shutdown_active_flag; endproperty
  a_swsd: assert property (p_swsd) else $error("software shutdown not taken");
  property p_pinwr; acc && pwrite && paddr == 12'h004 && !pwdata[15]
    |=> ##1 pin_drive_enables == $past(pin_wr, 2); endproperty
  a_pinwr: assert property (p_pinwr) else $error("pin enables not updated");
  property p_sdfall; $fell(shutdown_active_flag) |-> $past(swclr) || $past(autoclr);
  endproperty
  a_sdfall: assert property (p_sdfall) else $error("shutdown flag dropped alone");
endmodule
bind csgoc_ctrl csgoc_monitor #(.MULTI_OUT(MULTI_OUT)) u_mon (.ref_clk(ref_clk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pslverr(pslverr), .timebase_roll(timebase_roll),
  .capture_event(capture_event), .shutdown_active_flag(shutdown_active_flag),
  .capture_disable_flag(capture_disable_flag), .pin_drive_enables(pin_drive_enables),
  .capture_gated(capture_gated));

//--- csgoc_ctrl_bench.sv
// apb testbench for csgoc_ctrl
// assumes csgoc_monitor is bound from its own file
`timescale 1ns/1ps
module csgoc_ctrl_bench;
  reg ref_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, err, hit;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rd, rd_s;
  reg [12:0] lv = 13'h0; // source levels
  reg [2:0] ev = 3'h0; // compare, capture, rollover pulses
  reg mode_signal = 0, timer_mode = 0;
  wire [31:0] prdata;
  wire pready, pslverr, sdf, cdf, csrc, cg, aux;
  wire [5:0] pins, pins_s;
  wire [31:0] prdata_s;
  integer n_errors = 0, n_tests = 0, i, cyc = 0;
  // capture select code to source level index
  int idx[8] = '{12, 0, 1, 8, 5, 9, 10, 11};
  // {expect, mode, timer, pulse, select}
  reg [7:0] aux_tab[6] = '{8'h85, 8'h04, 8'h8B, 8'h93, 8'h2B, 8'hC2};
  always #5 ref_clk = ~ref_clk;
  csgoc_ctrl #(.MULTI_OUT(1)) DUT (.ref_clk(ref_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comparator_1(lv[0]), .comparator_2(lv[1]),
    .comparator_3(lv[8]), .fault_input_a(lv[6]), .fault_input_b(lv[7]),
    .fault_input_c(lv[2]), .fault_input_d(lv[3]), .logic_cell_1(lv[5]),
    .logic_cell_2(lv[9]), .logic_cell_3(lv[10]), .logic_cell_4(lv[11]),
    .capture_pin(lv[12]), .own_capture(lv[4]), .timebase_roll(ev[0]),
    .capture_event(ev[1]), .compare_event(ev[2]), .mode_signal(mode_signal),
    .timer_mode(timer_mode), .shutdown_active_flag(sdf), .capture_disable_flag(cdf),
    .pin_drive_enables(pins), .capture_source(csrc), .capture_gated(cg), .aux_out(aux));
  // single-output build on the same stimulus
  csgoc_ctrl #(.MULTI_OUT(0)) DUT_single (.ref_clk(ref_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_s),
    .pready(), .pslverr(), .comparator_1(lv[0]), .comparator_2(lv[1]),
    .comparator_3(lv[8]), .fault_input_a(lv[6]), .fault_input_b(lv[7]),
    .fault_input_c(lv[2]), .fault_input_d(lv[3]), .logic_cell_1(lv[5]),
    .logic_cell_2(lv[9]), .logic_cell_3(lv[10]), .logic_cell_4(lv[11]),
    .capture_pin(lv[12]), .own_capture(lv[4]), .timebase_roll(ev[0]),
    .capture_event(ev[1]), .compare_event(ev[2]), .mode_signal(mode_signal),
    .timer_mode(timer_mode), .shutdown_active_flag(), .capture_disable_flag(),
    .pin_drive_enables(pins_s), .capture_source(), .capture_gated(), .aux_out());
  // compare and count
  task chk(input [31:0] seen, input [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task xfer(input w, input [11:0] a, input [31:0] d);
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    // pready sampled high or the bench timeout ends this wait
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    rd_s = prdata_s;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task cyc_n(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one-cycle event pulse
  task pulse(input [2:0] p);
    ev <= p;
    @(posedge ref_clk);
    ev <= 3'h0;
  endtask
  task summarize;
    if (n_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, well above the expected run length
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors = n_errors + 1;
      summarize();
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 0;
    xfer(0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    xfer(0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    xfer(1, 12'h000, 32'hFFFFFFFF);
    xfer(0, 12'h000, 32'h0);
    chk(rd, 32'h0000D0FF);
    xfer(1, 12'h004, 32'hFFFFFFFF);
    xfer(0, 12'h004, 32'h0);
    chk(rd, 32'h0000BFDF);
    chk(rd_s, 32'h000081DF);
    xfer(1, 12'h000, 32'h0);
    xfer(1, 12'h004, 32'h0);
    xfer(1, 12'h008, 32'h0);
    xfer(0, 12'h00C, 32'h0);
    chk({31'h0, err}, 32'h1);
    // each source alone, others high but masked, manual clear
    for (i = 0; i < 8; i++) begin
      xfer(1, 12'h000, 32'h1 << i);
      lv <= 13'h00FF ^ (13'h1 << i);
      cyc_n(3);
      chk(sdf, 32'h0);
      lv <= 13'h1 << i;
      cyc_n(3);
      chk(sdf, 32'h1);
      lv <= 13'h0;
      cyc_n(3);
      chk(sdf, 32'h1);
      xfer(1, 12'h008, 32'h0);
      cyc_n(2);
      chk(sdf, 32'h0);
    end
    xfer(1, 12'h000, 32'h9000);
    cyc_n(3);
    chk(sdf, 32'h1);
    xfer(1, 12'h000, 32'h8000);
    cyc_n(3);
    chk(sdf, 32'h1);
    pulse(3'h1);
    cyc_n(3);
    chk(sdf, 32'h0);
    xfer(1, 12'h000, 32'h5000);
    cyc_n(4);
    chk(sdf, 32'h0);
    pulse(3'h1);
    cyc_n(3);
    chk(sdf, 32'h1);
    xfer(1, 12'h000, 32'h0);
    xfer(1, 12'h008, 32'h0);
    xfer(1, 12'h004, 32'h3F00);
    cyc_n(3);
    chk(pins, 32'h3F);
    chk(pins_s, 32'h01);
    xfer(1, 12'h004, 32'h8000);
    cyc_n(3);
    chk(pins, 32'h3F);
    pulse(3'h1);
    cyc_n(3);
    chk(pins, 32'h0);
    // every capture source code
    for (i = 0; i < 8; i++) begin
      xfer(1, 12'h004, i);
      lv <= ~(13'h1 << idx[i]);
      cyc_n(3);
      chk(csrc, 32'h0);
      lv <= 13'h1 << idx[i];
      cyc_n(3);
      chk(csrc, 32'h1);
    end
    lv <= 13'h0;
    xfer(1, 12'h004, 32'h0);
    cyc_n(3);
    chk(cdf, 32'h1);
    pulse(3'h2);
    cyc_n(1);
    chk(cg, 32'h0);
    xfer(1, 12'h000, 32'h1000);
    cyc_n(3);
    chk(cdf, 32'h0);
    pulse(3'h2);
    cyc_n(1);
    chk(cg, 32'h1);
    xfer(1, 12'h004, 32'h0080);
    xfer(1, 12'h008, 32'h0414);
    xfer(1, 12'h000, 32'h0);
    cyc_n(3);
    chk(cdf, 32'h1);
    xfer(1, 12'h004, 32'h0040);
    xfer(1, 12'h008, 32'h0414);
    xfer(1, 12'h000, 32'h1000);
    cyc_n(3);
    chk(cdf, 32'h0);
    xfer(0, 12'h008, 32'h0);
    chk(rd, 32'h00000010);
    // auxiliary output select table
    for (i = 0; i < 6; i++) begin
      xfer(1, 12'h004, {27'h0, aux_tab[i][1:0], 3'h0});
      {mode_signal, timer_mode} <= aux_tab[i][6:5];
      pulse(aux_tab[i][4:2]);
      hit = 0;
      repeat (3) begin
        @(posedge ref_clk);
        hit = hit | aux;
      end
      chk(hit, aux_tab[i][7]);
    end
    summarize();
  end
endmodule
